//--- include/fsmr_pkg.sv
// constants, field layouts and carriers of the fail-safe register bank
package fsmr_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_GROUP = 8'h00;
  localparam logic [7:0] ADDR_REACT_A = 8'h04;
  localparam logic [7:0] ADDR_REACT_B = 8'h08;
  localparam logic [7:0] ADDR_FSM_CFG = 8'h0c;
  localparam logic [7:0] ADDR_SCALE = 8'h10;
  localparam logic [7:0] ADDR_MON_STAT = 8'h14;
  localparam logic [7:0] ADDR_DIAG_STAT = 8'h18;
  // writable bits and reset values
  localparam logic [31:0] REACT_A_MASK = 32'h00f0_0f00;
  localparam logic [31:0] REACT_A_RST = 32'h00d0_0d00;
  localparam logic [31:0] REACT_B_MASK = 32'h0000_0f00;
  localparam logic [31:0] REACT_B_RST = 32'h0000_0d00;
  localparam logic [31:0] FSM_CFG_MASK = 32'h00c2_1000;
  localparam logic [31:0] FSM_CFG_RST = 32'h0040_0000;
  localparam logic [31:0] SCALE_MASK = 32'h00f8_0000;
  localparam logic [31:0] MON_MASK = 32'h00f0_3300;
  localparam logic [31:0] MON_OVUV_MASK = 32'h00f0_3000;
  localparam logic [31:0] DIAG_MASK = 32'h0081_0600;
  // field positions
  localparam int GRP_COMM = 23;
  localparam int GRP_PIN = 21;
  localparam int GRP_MON = 20;
  localparam int DUR_BIT = 17;
  localparam int TOFF_BIT = 12;
  localparam int CNT_LSB = 8;
  localparam int OFS_LSB = 19;
  localparam int LIM_LSB = 22;
  localparam int DG_POWER_GOOD_PIN = 23;
  localparam int DG_RESET = 16;
  localparam int DG_VIOL = 10;
  localparam int DG_CRC = 9;
  localparam logic [4:0] OFS_MAX = 5'h10;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RST_LONG_US = 10000;
  localparam int RST_SHORT_US = 1000;
  localparam int RST_LONG_CYC = RST_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int RST_SHORT_CYC = RST_SHORT_US * 1000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic core_ov; logic core_uv; logic io_ov; logic io_uv;
    logic aux_ov;  logic aux_uv;  logic ref_ov; logic osc_drift;
  } fsmr_mon_evt_t;

  typedef struct packed {
    logic power_good_pin_short; logic reset_short; logic viol; logic crc;
  } fsmr_diag_evt_t;

  typedef struct packed {
    logic [1:0] core_over_reaction;
    logic [1:0] core_under_reaction;
    logic [1:0] io_over_reaction;
    logic [1:0] io_under_reaction;
    logic [1:0] aux_over_reaction;
    logic [1:0] aux_under_reaction;
    logic [1:0] fault_count_limit;
    logic       reset_pulse_length_sel;
    logic       long_reset_timer_off;
    logic [4:0] scaling_offset_code;
  } fsmr_cfg_t;
endpackage : fsmr_pkg

//--- hdl/fsmr_regs.sv
// apb register bank of the fail-safe monitor and fault state machine
module fsmr_regs #(
  parameter int LONG_CYC  = fsmr_pkg::RST_LONG_CYC,
  parameter int SHORT_CYC = fsmr_pkg::RST_SHORT_CYC
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // fault detectors, one-cycle event pulses, and the live fault count
  input  wire fsmr_pkg::fsmr_mon_evt_t  mon_evt,
  input  wire fsmr_pkg::fsmr_diag_evt_t diag_evt,
  input  wire logic [3:0]               fault_count_value,
  // configuration and monitor flags to the fail-safe logic
  output fsmr_pkg::fsmr_cfg_t           cfg,
  output logic      [16:0]              reset_pulse_cycles,
  output logic      [31:0]              mon_flags
);
  logic [31:0] react_a_q, react_b_q, fsm_cfg_q, scale_q;
  logic [31:0] mon_q, diag_q, prdata_q;
  logic [16:0] pulse_q;
  logic        pready_q, pslverr_q;
  logic [31:0] mon_set, diag_set, rd_word;
  logic        wr_en, setup, known, comm_g, pin_g, mon_g;
  logic [4:0]  ofs_wr;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite;

  // events placed on their status bit positions
  assign mon_set = {8'h00, mon_evt.core_ov, mon_evt.core_uv,
                    mon_evt.io_ov, mon_evt.io_uv, 4'h0,
                    2'b00, mon_evt.aux_ov, mon_evt.aux_uv,
                    2'b00, mon_evt.ref_ov,
                    mon_evt.osc_drift, 8'h00};
  always_comb
  begin
    diag_set = '0;
    diag_set[fsmr_pkg::DG_POWER_GOOD_PIN] = diag_evt.power_good_pin_short;
    diag_set[fsmr_pkg::DG_RESET] = diag_evt.reset_short;
    diag_set[fsmr_pkg::DG_VIOL] = diag_evt.viol;
    diag_set[fsmr_pkg::DG_CRC] = diag_evt.crc;
  end

  // group summaries are live so a read never lags the flags
  assign comm_g = diag_q[fsmr_pkg::DG_VIOL] | diag_q[fsmr_pkg::DG_CRC];
  assign pin_g = diag_q[fsmr_pkg::DG_POWER_GOOD_PIN] | diag_q[fsmr_pkg::DG_RESET];
  assign mon_g = |(mon_q & fsmr_pkg::MON_OVUV_MASK);

  // address decode and read mux
  always_comb
  begin
    known = 1'b1;
    rd_word = '0;
    unique case (paddr)
      fsmr_pkg::ADDR_GROUP:
      begin
        rd_word[fsmr_pkg::GRP_COMM] = comm_g;
        rd_word[fsmr_pkg::GRP_PIN] = pin_g;
        rd_word[fsmr_pkg::GRP_MON] = mon_g;
      end
      fsmr_pkg::ADDR_REACT_A: rd_word = react_a_q;
      fsmr_pkg::ADDR_REACT_B: rd_word = react_b_q;
      fsmr_pkg::ADDR_FSM_CFG:
      begin
        rd_word = fsm_cfg_q;
        rd_word[fsmr_pkg::CNT_LSB +: 4] = fault_count_value;
      end
      fsmr_pkg::ADDR_SCALE: rd_word = scale_q;
      fsmr_pkg::ADDR_MON_STAT: rd_word = mon_q;
      fsmr_pkg::ADDR_DIAG_STAT: rd_word = diag_q;
      default: known = 1'b0;
    endcase
  end

  // no wait state: read data captured in setup, answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && !known;
      if (setup && !pwrite)
        prdata_q <= rd_word;
      else if (!psel)
        prdata_q <= '0;
    end
  end

  // plain stored configuration words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      react_a_q <= fsmr_pkg::REACT_A_RST;
      react_b_q <= fsmr_pkg::REACT_B_RST;
      fsm_cfg_q <= fsmr_pkg::FSM_CFG_RST;
    end
    else if (wr_en)
    begin
      if (paddr == fsmr_pkg::ADDR_REACT_A)
        react_a_q <= pwdata & fsmr_pkg::REACT_A_MASK;
      if (paddr == fsmr_pkg::ADDR_REACT_B)
        react_b_q <= pwdata & fsmr_pkg::REACT_B_MASK;
      if (paddr == fsmr_pkg::ADDR_FSM_CFG)
        fsm_cfg_q <= pwdata & fsmr_pkg::FSM_CFG_MASK;
    end
  end

  // offset codes past the -100 mV step saturate there
  assign ofs_wr = (pwdata[fsmr_pkg::OFS_LSB +: 5] > fsmr_pkg::OFS_MAX)
                ? fsmr_pkg::OFS_MAX : pwdata[fsmr_pkg::OFS_LSB +: 5];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scale_q <= '0;
    else if (wr_en && paddr == fsmr_pkg::ADDR_SCALE)
      scale_q <= {8'h00, ofs_wr, 19'h0_0000};
  end

  // sticky flags: an event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mon_q <= '0;
      diag_q <= '0;
    end
    else
    begin
      mon_q <= ((mon_q & ~((wr_en && paddr == fsmr_pkg::ADDR_MON_STAT)
               ? pwdata : '0)) | mon_set) & fsmr_pkg::MON_MASK;
      diag_q <= ((diag_q & ~((wr_en && paddr == fsmr_pkg::ADDR_DIAG_STAT)
               ? pwdata : '0)) | diag_set) & fsmr_pkg::DIAG_MASK;
    end
  end

  // pulse length in cycles for the reset driver
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_q <= 17'(LONG_CYC);
    else
      pulse_q <= fsm_cfg_q[fsmr_pkg::DUR_BIT] ? 17'(SHORT_CYC)
                                               : 17'(LONG_CYC);
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign reset_pulse_cycles = pulse_q;
  assign mon_flags = mon_q;
  assign cfg = '{core_over_reaction: react_a_q[23:22],
                 core_under_reaction: react_a_q[21:20],
                 io_over_reaction: react_a_q[11:10],
                 io_under_reaction: react_a_q[9:8],
                 aux_over_reaction: react_b_q[11:10],
                 aux_under_reaction: react_b_q[9:8],
                 fault_count_limit: fsm_cfg_q[fsmr_pkg::LIM_LSB +: 2],
                 reset_pulse_length_sel: fsm_cfg_q[fsmr_pkg::DUR_BIT],
                 long_reset_timer_off: fsm_cfg_q[fsmr_pkg::TOFF_BIT],
                 scaling_offset_code: scale_q[fsmr_pkg::OFS_LSB +: 5]};

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  a_comm_group: assert property (s_rd(fsmr_pkg::ADDR_GROUP) |=>
    prdata[23] == $past(diag_q[10] | diag_q[9]))
    else $error("comm group wrong");
  a_pin_group: assert property (s_rd(fsmr_pkg::ADDR_GROUP) |=>
    prdata[21] == $past(diag_q[23] | diag_q[16]))
    else $error("pin group wrong");
  a_mon_group: assert property (s_rd(fsmr_pkg::ADDR_GROUP) |=>
    prdata[20] == $past(|mon_q[23:20] | |mon_q[13:12]))
    else $error("monitor group wrong");
  a_group_clear: assert property (s_rd(fsmr_pkg::ADDR_GROUP) ##1
    (prdata[20] == 1'b0) |-> $past(mon_q & fsmr_pkg::MON_OVUV_MASK) == '0)
    else $error("group cleared early");
  a_pulse_len: assert property (fsm_cfg_q[17] |=>
    reset_pulse_cycles == 17'(SHORT_CYC))
    else $error("pulse length wrong");
  a_timer_off: assert property (s_wr(fsmr_pkg::ADDR_FSM_CFG) |=>
    cfg.long_reset_timer_off == $past(pwdata[12]))
    else $error("timer off not stored");
  a_count_read: assert property (s_rd(fsmr_pkg::ADDR_FSM_CFG) |=>
    prdata[11:8] == $past(fault_count_value))
    else $error("count read wrong");
  a_offset_max: assert property (cfg.scaling_offset_code <= 5'h10)
    else $error("offset out of range");
  a_core_set: assert property (mon_evt.core_ov |=> mon_q[23])
    else $error("core over not set");
  a_io_set: assert property (mon_evt.io_uv |=> mon_q[20])
    else $error("io under not set");
  a_aux_set: assert property (mon_evt.aux_ov |=> mon_q[13])
    else $error("aux over not set");
  a_ref_set: assert property (mon_evt.ref_ov |=> mon_q[9])
    else $error("ref over not set");
  a_osc_set: assert property (mon_evt.osc_drift |=> mon_q[8])
    else $error("drift not set");
  a_flag_hold: assert property (mon_q[22] && !(psel && penable
    && pready && pwrite && paddr == fsmr_pkg::ADDR_MON_STAT
    && pwdata[22]) |=> mon_q[22])
    else $error("flag lost");
  a_diag_set: assert property (diag_evt.power_good_pin_short
    ##1 1'b1 |-> diag_q[23] ##1 prdata[31:24] == 8'h00)
    else $error("power_good_pin short not set");
  a_rst_short: assert property (diag_evt.reset_short |=> diag_q[16])
    else $error("reset short not set");
  a_crc_set: assert property (diag_evt.crc |=> diag_q[9])
    else $error("crc not set");
endmodule : fsmr_regs

//--- test/fsmr_tb.sv
// self-checking bench of the fail-safe register bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // clock, reset and apb
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  // detectors and configuration
  fsmr_pkg::fsmr_mon_evt_t  mon_evt;
  fsmr_pkg::fsmr_diag_evt_t diag_evt;
  logic [3:0]              fcv;
  fsmr_pkg::fsmr_cfg_t     cfg;
  logic [16:0]             rpc;
  logic [31:0]             mon_flags;
  int                      err_total;
  int                      n_compared;
  logic [31:0]             rv;
  logic [31:0]             ex;
  logic                    ev;
  int pos_m[8] = '{8, 9, 12, 13, 20, 21, 22, 23};
  int pos_d[4] = '{9, 10, 16, 23};
  logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] rr[7] = '{32'h0000_0000, 32'h00d0_0d00, 32'h0000_0d00,
    32'h0040_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  // short pulse counts keep the run brief
  fsmr_regs #(.LONG_CYC(20), .SHORT_CYC(4)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mon_evt(mon_evt), .diag_evt(diag_evt),
    .fault_count_value(fcv), .cfg(cfg), .reset_pulse_cycles(rpc),
    .mon_flags(mon_flags));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // one apb transfer; a missing pready is left to the watchdog
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r  = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    #1_000_000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    err_total = 0;
    n_compared = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    mon_evt = '0;
    diag_evt = '0;
    fcv = 4'h0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped address
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i], 32'h0, rv);
      chk(rv, rr[i]);
    end
    chk(32'(rpc), 32'd20);
    apb(1'b0, 8'h1c, 32'h0, rv);
    chk({rv[30:0], ev}, 32'h0000_0001);
    // reaction fields are plain storage
    apb(1'b1, 8'h04, 32'hffff_ffff, rv);
    apb(1'b0, 8'h04, 32'h0, rv);
    chk(rv, fsmr_pkg::REACT_A_MASK);
    apb(1'b1, 8'h04, 32'h0060_0900, rv);
    apb(1'b1, 8'h08, 32'hffff_ffff, rv);
    apb(1'b0, 8'h08, 32'h0, rv);
    chk(rv, fsmr_pkg::REACT_B_MASK);
    chk(32'(cfg[20:9]), 32'h0000_069f);
    // fault machine configuration and live counter
    fcv <= 4'hc;
    apb(1'b1, 8'h0c, 32'hffff_ffff, rv);
    apb(1'b0, 8'h0c, 32'h0, rv);
    chk(rv, fsmr_pkg::FSM_CFG_MASK | 32'h0000_0c00);
    chk(32'(rpc), 32'd4);
    chk(32'(cfg.long_reset_timer_off), 32'h1);
    apb(1'b1, 8'h0c, 32'h0000_0000, rv);
    // pulse length follows the config bit one cycle later
    repeat (2) @(posedge pclk);
    chk(32'(rpc), 32'd20);
    chk(32'(cfg.long_reset_timer_off), 32'h0);
    for (int v = 0; v < 13; v++)
    begin
      fcv <= 4'(v);
      apb(1'b0, 8'h0c, 32'h0, rv);
      chk(rv & 32'h0000_0f00, 32'(v) << 8);
    end
    // scaling offset code, top code and saturation
    apb(1'b1, 8'h10, 32'h0050_0000, rv);
    @(posedge pclk);
    chk(32'(cfg.scaling_offset_code), 32'd10);
    apb(1'b1, 8'h10, 32'hffff_ffff, rv);
    apb(1'b0, 8'h10, 32'h0, rv);
    chk(rv, 32'h0080_0000);
    // each monitor event sets its sticky flag
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      mon_evt <= fsmr_pkg::fsmr_mon_evt_t'(8'h01 << i);
      @(posedge pclk);
      mon_evt <= '0;
      ex = 32'h0000_0001 << pos_m[i];
      apb(1'b0, 8'h14, 32'h0, rv);
      chk(rv, ex);
      chk(mon_flags, ex);
      apb(1'b0, 8'h00, 32'h0, rv);
      chk(rv, (i >= 2) ? 32'h0010_0000 : 32'h0);
      apb(1'b1, 8'h14, ~ex, rv);
      apb(1'b0, 8'h14, 32'h0, rv);
      chk(rv, ex);
      apb(1'b1, 8'h14, ex, rv);
      apb(1'b0, 8'h00, 32'h0, rv);
      chk(rv, 32'h0000_0000);
    end
    // diagnostic flags feed the pin and comm groups
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      diag_evt <= fsmr_pkg::fsmr_diag_evt_t'(4'h1 << i);
      @(posedge pclk);
      diag_evt <= '0;
      apb(1'b0, 8'h00, 32'h0, rv);
      chk(rv, (i < 2) ? 32'h0080_0000 : 32'h0020_0000);
      apb(1'b1, 8'h18, 32'h0000_0001 << pos_d[i], rv);
    end
    // group stays set until the last source is cleared
    @(posedge pclk);
    diag_evt <= fsmr_pkg::fsmr_diag_evt_t'(4'h3);
    @(posedge pclk);
    diag_evt <= '0;
    apb(1'b1, 8'h18, 32'h0000_0200, rv);
    apb(1'b0, 8'h00, 32'h0, rv);
    chk(rv, 32'h0080_0000);
    apb(1'b1, 8'h18, 32'h0000_0400, rv);
    apb(1'b0, 8'h00, 32'h0, rv);
    chk(rv, 32'h0000_0000);
    // a mid-run reset clears a set flag and the offset code
    apb(1'b1, 8'h10, 32'h0050_0000, rv);
    @(posedge pclk);
    mon_evt <= fsmr_pkg::fsmr_mon_evt_t'(8'h80);
    @(posedge pclk);
    mon_evt <= '0;
    @(posedge pclk);
    chk(mon_flags, 32'h0080_0000);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h14, 32'h0, rv);
    chk(rv, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0, rv);
    chk(rv, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : tb
